// file: src/port9_pkg.sv
// Constants for the port 9 general I/O and LCD pin multiplexer
package port9_pkg;

   // Register byte addresses
   localparam logic [31:0] OUTPUT_DATA_ADDR   = 32'h0000FFDC;
   localparam logic [31:0] PIN_DIRECTION_ADDR = 32'h0000FFEC;
   localparam logic [31:0] LCD_PORT_CTRL_ADDR = 32'h0000FFF0;

   // Values after reset
   localparam logic [7:0] OUTPUT_DATA_RESET   = 8'h00;
   localparam logic [7:0] PIN_DIRECTION_RESET = 8'h00;
   localparam logic [3:0] DRIVE_SELECT_RESET  = 4'h0;
   localparam logic       EXPAND_RESET        = 1'b0;

   // Read values
   localparam logic [7:0]  DIRECTION_READ_VALUE = 8'hFF;
   localparam logic [31:0] UNMAPPED_READ_VALUE  = 32'h00000000;

   // Fields of the LCD port control register
   localparam int          DRIVE_SELECT_LSB = 0;
   localparam int          DRIVE_SELECT_W   = 4;
   localparam int          EXPAND_BIT       = 4;
   localparam logic [3:0]  SELECT_GPIO      = 4'h0;

   // Pins carrying external LCD controller signals
   localparam int PIN_LATCH_CLOCK_ONE = 7;
   localparam int PIN_LATCH_CLOCK_TWO = 6;
   localparam int PIN_SERIAL_DATA     = 5;
   localparam int PIN_ALTERNATING     = 4;
   localparam int EXPAND_PIN_LOW      = 4;

   // Segment number carried by pin 0
   localparam int FIRST_SEGMENT = 33;

   // Bus transfer encoding
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

endpackage : port9_pkg

// file: src/port9_pin_select.sv
// Per-pin function selector for port 9
`timescale 1ns/10ps
module port9_pin_select #(
   parameter int PINS = 8
) (
   // Port registers
   input  wire logic [PINS-1:0] gpio_data_in,
   input  wire logic [PINS-1:0] gpio_dir_in,
   // LCD port control
   input  wire logic [3:0]      drive_select_in,
   input  wire logic            external_expand_in,
   // LCD sources
   input  wire logic [PINS-1:0] segment_in,
   input  wire logic [3:0]      external_in,
   // Selected pin function
   output logic      [PINS-1:0] drive_out,
   output logic      [PINS-1:0] enable_out
);

   logic segment_mode;

   // Any non-zero select hands the pins, except upper pins under expansion, to the segment driver
   assign segment_mode = (drive_select_in != port9_pkg::SELECT_GPIO);

   // One selector per pin; upper pins also carry controller signals
   for (genvar i = 0; i < PINS; i++) begin : g_pin
      if (i >= port9_pkg::EXPAND_PIN_LOW) begin : g_upper
         always_comb begin
            if (external_expand_in) begin
               drive_out[i]  = external_in[i - port9_pkg::EXPAND_PIN_LOW];
               enable_out[i] = 1'b1;
            end else if (segment_mode) begin
               drive_out[i]  = segment_in[i];
               enable_out[i] = 1'b1;
            end else begin
               drive_out[i]  = gpio_data_in[i];
               enable_out[i] = gpio_dir_in[i];
            end
         end
      end else begin : g_lower
         always_comb begin
            if (segment_mode) begin
               drive_out[i]  = segment_in[i];
               enable_out[i] = 1'b1;
            end else begin
               drive_out[i]  = gpio_data_in[i];
               enable_out[i] = gpio_dir_in[i];
            end
         end
      end
   end

endmodule // port9_pin_select

// file: src/port9_gpio_lcd_pin_mux.sv
// Port 9 general I/O with LCD pin multiplexing, AHB-Lite register slave
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module port9_gpio_lcd_pin_mux #(
   parameter int PINS = 8
) (
   // Clock and reset
   input  wire logic            mclk_in,
   input  wire logic            sys_rst_in,
   // AHB-Lite slave
   input  wire logic            hsel_in,
   input  wire logic [31:0]     haddr_in,
   input  wire logic [1:0]      htrans_in,
   input  wire logic            hwrite_in,
   input  wire logic [2:0]      hsize_in,
   input  wire logic [31:0]     hwdata_in,
   input  wire logic            hready_in,
   output logic      [31:0]     hrdata_out,
   output logic                 hreadyout_out,
   output logic                 hresp_out,
   // Operating mode
   input  wire logic            standby_mode_in,
   input  wire logic            retain_mode_in,
   // LCD controller sources
   input  wire logic [PINS-1:0] lcd_drive_output_n_in,
   input  wire logic            lcd_latch_clock_one_in,
   input  wire logic            lcd_latch_clock_two_in,
   input  wire logic            lcd_serial_data_in,
   input  wire logic            lcd_alternating_in,
   // Port pins
   input  wire logic [PINS-1:0] pin_in,
   output logic      [PINS-1:0] pin_out,
   output logic      [PINS-1:0] pin_oe_n_out
);

   logic [PINS-1:0] port9_output_data;
   logic [PINS-1:0] port9_pin_direction;
   logic [3:0]      lcd_drive_pin_select;
   logic            lcd_external_expand;
   logic [PINS-1:0] next_output_data;
   logic [PINS-1:0] next_pin_direction;
   logic [3:0]      next_drive_select;
   logic            next_external_expand;
   logic            wr_pending;
   logic [31:0]     wr_addr;
   logic            addr_phase;
   logic            data_write;
   logic [31:0]     next_rdata;
   logic [PINS-1:0] port_readback;
   logic [3:0]      external_sig;
   logic [PINS-1:0] mux_drive;
   logic [PINS-1:0] mux_enable;

   // A transfer is taken only when the bus is ready; hsize is ignored, word access only
   assign addr_phase = hsel_in && htrans_in[1] && hready_in;
   assign data_write = wr_pending;

   // Address phase of a write is remembered for its data phase
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         wr_pending <= 1'b0;
         wr_addr    <= 32'h00000000;
      end else begin
         wr_pending <= addr_phase && hwrite_in;
         wr_addr    <= haddr_in;
      end
   end

   // Next register values; write data lands at the end of the data phase
   always_comb begin
      next_output_data     = port9_output_data;
      next_pin_direction   = port9_pin_direction;
      next_drive_select    = lcd_drive_pin_select;
      next_external_expand = lcd_external_expand;
      if (data_write && wr_addr == port9_pkg::OUTPUT_DATA_ADDR) begin
         next_output_data = hwdata_in[PINS-1:0];
      end
      if (data_write && wr_addr == port9_pkg::PIN_DIRECTION_ADDR) begin
         next_pin_direction = hwdata_in[PINS-1:0];
      end
      if (data_write && wr_addr == port9_pkg::LCD_PORT_CTRL_ADDR) begin
         next_drive_select    = hwdata_in[port9_pkg::DRIVE_SELECT_LSB +: port9_pkg::DRIVE_SELECT_W];
         next_external_expand = hwdata_in[port9_pkg::EXPAND_BIT];
      end
   end

   // Port data register
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         port9_output_data <= port9_pkg::OUTPUT_DATA_RESET;
      end else begin
         port9_output_data <= next_output_data;
      end
   end

   // Direction register; sets the pin enables and the read-back mix, but reads of its own address never see it
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         port9_pin_direction <= port9_pkg::PIN_DIRECTION_RESET;
      end else begin
         port9_pin_direction <= next_pin_direction;
      end
   end

   // LCD port control register
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         lcd_drive_pin_select <= port9_pkg::DRIVE_SELECT_RESET;
         lcd_external_expand  <= port9_pkg::EXPAND_RESET;
      end else begin
         lcd_drive_pin_select <= next_drive_select;
         lcd_external_expand  <= next_external_expand;
      end
   end

   // Read back mixes stored data and live pin level per direction bit;
   // next values are used so a read right after a write sees the new data
   assign port_readback = (next_pin_direction & next_output_data)
                        | (~next_pin_direction & pin_in);

   // Read data selection, registered for the data phase
   always_comb begin
      next_rdata = port9_pkg::UNMAPPED_READ_VALUE;
      case (haddr_in)
         port9_pkg::OUTPUT_DATA_ADDR: begin
            next_rdata[PINS-1:0] = port_readback;
         end
         port9_pkg::PIN_DIRECTION_ADDR: begin
            next_rdata[7:0] = port9_pkg::DIRECTION_READ_VALUE;
         end
         port9_pkg::LCD_PORT_CTRL_ADDR: begin
            next_rdata[port9_pkg::DRIVE_SELECT_LSB +: port9_pkg::DRIVE_SELECT_W] = next_drive_select;
            next_rdata[port9_pkg::EXPAND_BIT] = next_external_expand;
         end
         default: begin
            next_rdata = port9_pkg::UNMAPPED_READ_VALUE;
         end
      endcase
   end

   // Bus answer: zero wait states, always OKAY
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         hrdata_out    <= 32'h00000000;
         hreadyout_out <= 1'b1;
         hresp_out     <= port9_pkg::HRESP_OKAY;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out     <= port9_pkg::HRESP_OKAY;
         if (addr_phase && !hwrite_in) begin
            hrdata_out <= next_rdata;
         end
      end
   end

   // Controller signals in pin order 4..7
   assign external_sig = {lcd_latch_clock_one_in, lcd_latch_clock_two_in,
                          lcd_serial_data_in, lcd_alternating_in};

   // Pin function selection works on next values so pins follow a write at once
   port9_pin_select #(
      .PINS (PINS)
   ) u_select (
      .gpio_data_in       (next_output_data),
      .gpio_dir_in        (next_pin_direction),
      .drive_select_in    (next_drive_select),
      .external_expand_in (next_external_expand),
      .segment_in         (lcd_drive_output_n_in),
      .external_in        (external_sig),
      .drive_out          (mux_drive),
      .enable_out         (mux_enable)
   );

   // Pin drivers: float in reset and standby, frozen in retention modes
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         pin_out      <= '0;
         pin_oe_n_out <= '1;
      end else if (standby_mode_in) begin
         pin_out      <= '0;
         pin_oe_n_out <= '1;
      end else if (retain_mode_in) begin
         pin_out      <= pin_out;
         pin_oe_n_out <= pin_oe_n_out;
      end else begin
         pin_out      <= mux_drive;
         pin_oe_n_out <= ~mux_enable;
      end
   end

   // Checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);

   logic active_mode;
   logic gpio_mode;
   assign active_mode = !standby_mode_in && !retain_mode_in;
   assign gpio_mode   = (next_drive_select == port9_pkg::SELECT_GPIO) && !next_external_expand;

   // Checked one edge after a reset edge, so the unknown start-up values are never judged
   chk_data_after_reset: assert property (disable iff (1'b0)
      sys_rst_in |=> port9_output_data == port9_pkg::OUTPUT_DATA_RESET && pin_oe_n_out == '1)
      else $error("data register or pins not reset");

   chk_dir_after_reset: assert property (disable iff (1'b0)
      sys_rst_in |=> port9_pin_direction == port9_pkg::PIN_DIRECTION_RESET)
      else $error("direction register not cleared by reset");

   chk_read_output_bits: assert property (
      addr_phase && !hwrite_in && haddr_in == port9_pkg::OUTPUT_DATA_ADDR
      |=> (hrdata_out[PINS-1:0] & $past(next_pin_direction))
          == ($past(next_output_data) & $past(next_pin_direction)))
      else $error("output bit read does not return data register");

   chk_read_input_bits: assert property (
      addr_phase && !hwrite_in && haddr_in == port9_pkg::OUTPUT_DATA_ADDR
      |=> (hrdata_out[PINS-1:0] & ~$past(next_pin_direction)) == ($past(pin_in) & ~$past(next_pin_direction)))
      else $error("input bit read does not return pin level");

   chk_dir_reads_ones: assert property (
      addr_phase && !hwrite_in && haddr_in == port9_pkg::PIN_DIRECTION_ADDR
      |=> hrdata_out == 32'h000000FF)
      else $error("direction register read not all ones");

   chk_write_drives_pin: assert property (
      data_write && wr_addr == port9_pkg::PIN_DIRECTION_ADDR && gpio_mode && active_mode
      |=> pin_oe_n_out == ~$past(hwdata_in[PINS-1:0]) && pin_out == $past(next_output_data))
      else $error("direction write not reflected on pin at completion edge");

   chk_gpio_enable: assert property (
      gpio_mode && active_mode |=> pin_oe_n_out == ~$past(next_pin_direction))
      else $error("GPIO enable does not follow direction");

   chk_segment_lower: assert property (
      next_drive_select != port9_pkg::SELECT_GPIO && active_mode
      |=> pin_oe_n_out[3:0] == 4'h0 && pin_out[3:0] == $past(lcd_drive_output_n_in[3:0]))
      else $error("lower pins not driving segments");

   chk_segment_upper: assert property (
      next_drive_select != port9_pkg::SELECT_GPIO && !next_external_expand && active_mode
      |=> pin_oe_n_out[7:4] == 4'h0 && pin_out[7:4] == $past(lcd_drive_output_n_in[7:4]))
      else $error("upper pins not driving segments");

   chk_expand_signals: assert property (
      next_external_expand && active_mode
      |=> pin_oe_n_out[7:4] == 4'h0
          && pin_out[port9_pkg::PIN_LATCH_CLOCK_ONE] == $past(lcd_latch_clock_one_in)
          && pin_out[port9_pkg::PIN_LATCH_CLOCK_TWO] == $past(lcd_latch_clock_two_in)
          && pin_out[port9_pkg::PIN_SERIAL_DATA] == $past(lcd_serial_data_in)
          && pin_out[port9_pkg::PIN_ALTERNATING] == $past(lcd_alternating_in))
      else $error("controller signals not on upper pins");

   chk_standby_float: assert property (
      standby_mode_in |=> pin_oe_n_out == '1)
      else $error("pins not floating in standby");

   chk_retain_hold: assert property (
      retain_mode_in && !standby_mode_in |=> $stable(pin_out) && $stable(pin_oe_n_out))
      else $error("pins changed in retention mode");

   cov_gpio_input_read: cover property (
      addr_phase && !hwrite_in && haddr_in == port9_pkg::OUTPUT_DATA_ADDR && next_pin_direction != '1);
   cov_segment_mode: cover property (next_drive_select != port9_pkg::SELECT_GPIO ##1 active_mode);
   cov_expand_mode: cover property (next_external_expand && active_mode);
   cov_retain_after_drive: cover property (pin_oe_n_out != '1 ##1 retain_mode_in [*3]);

endmodule // port9_gpio_lcd_pin_mux

// file: tb/port9_pin_partner.sv
// External circuitry on the port 9 pins: loads that drive released pins
`timescale 1ns/10ps
module port9_pin_partner (
   // Port side
   input  wire logic [7:0] drive_in,
   input  wire logic [7:0] oe_n_in,
   // Load behaviour
   input  wire logic [7:0] ext_level_in,
   input  wire logic       fight_in,
   // Resolved pin levels
   output logic      [7:0] level_out
);
   // A released pin shows the load level; a fighting load wins even on driven pins
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         level_out[i] = (oe_n_in[i] || fight_in) ? ext_level_in[i] : drive_in[i];
      end
   end
endmodule // port9_pin_partner

// file: tb/testbench.sv
// Self-checking bench for the port 9 GPIO and LCD pin multiplexer
`timescale 1ns/10ps
`define CHECK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp); end end
module testbench;
   logic        mclk_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic        hsel, hwrite, hready, hresp, standby, retain, fight;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [7:0]  seg_src, pin_in, pin_out, pin_oe_n, ext;
   logic [3:0]  ctl_src;
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          cycles = 0;

   initial begin
      hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0; haddr = 32'h0; hwdata = 32'h0;
      standby = 1'b0; retain = 1'b0; fight = 1'b0; seg_src = 8'h5A; ctl_src = 4'hB; ext = 8'h96;
   end

   // Clock at 250 MHz
   initial begin
      forever #2 mclk_in = ~mclk_in;
   end

   port9_gpio_lcd_pin_mux #(.PINS(8)) dut (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
      .standby_mode_in(standby), .retain_mode_in(retain), .lcd_drive_output_n_in(seg_src),
      .lcd_latch_clock_one_in(ctl_src[3]), .lcd_latch_clock_two_in(ctl_src[2]),
      .lcd_serial_data_in(ctl_src[1]), .lcd_alternating_in(ctl_src[0]),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(pin_oe_n));

   port9_pin_partner load (.drive_in(pin_out), .oe_n_in(pin_oe_n), .ext_level_in(ext),
      .fight_in(fight), .level_out(pin_in));

   // Closing report, reached from the main sequence or the watchdog
   task automatic finish_test();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Watchdog: the whole run needs well under a thousand cycles
   always @(posedge mclk_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         finish_test();
      end
   end

   // Hold reset for 20 cycles, then release after an edge
   task automatic do_reset();
      sys_rst_in <= 1'b1;
      repeat (20) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
   endtask

   // One AHB-Lite single transfer; wait states are honoured though none are expected
   task automatic bus_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= port9_pkg::HTRANS_NONSEQ;
      do @(posedge mclk_in); while (hready !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wr ? d : 32'h0;
      do @(posedge mclk_in); while (hready !== 1'b1);
      rd = hrdata;
      `CHECK(hresp, port9_pkg::HRESP_OKAY, "response")
   endtask

   task automatic check_read(input logic [31:0] a, input logic [31:0] exp);
      bus_xfer(1'b0, a, 32'h0);
      `CHECK(rd, exp, "read data")
   endtask

   // Pin state checked just after the edge that should have produced it
   task automatic check_pins(input logic [7:0] out_exp, input logic [7:0] oe_exp);
      #1;
      `CHECK(pin_out, out_exp, "pin drive")
      `CHECK(pin_oe_n, oe_exp, "pin enable")
   endtask

   initial begin
      do_reset();
      check_pins(8'h00, 8'hFF);
      check_read(port9_pkg::PIN_DIRECTION_ADDR, 32'h000000FF);
      check_read(port9_pkg::LCD_PORT_CTRL_ADDR, 32'h00000000);
      check_read(port9_pkg::OUTPUT_DATA_ADDR, 32'h00000096);
      check_read(32'h0000FFE0, port9_pkg::UNMAPPED_READ_VALUE);
      // Mixed directions; pins follow on the edge that ends each write
      bus_xfer(1'b1, port9_pkg::PIN_DIRECTION_ADDR, 32'h000000F0);
      check_pins(8'h00, 8'h0F);
      bus_xfer(1'b1, port9_pkg::OUTPUT_DATA_ADDR, 32'h000000A5);
      check_pins(8'hA5, 8'h0F);
      // A fighting load shows that output bits read the register, input bits the pin
      ext = 8'h3C;
      fight = 1'b1;
      check_read(port9_pkg::OUTPUT_DATA_ADDR, 32'h000000AC);
      fight <= 1'b0;
      check_read(port9_pkg::PIN_DIRECTION_ADDR, 32'h000000FF);
      // Every non-zero select hands all pins to the segment drive
      for (int s = 1; s < 16; s++) begin
         bus_xfer(1'b1, port9_pkg::LCD_PORT_CTRL_ADDR, 32'(s));
         @(posedge mclk_in);
         check_pins(seg_src, 8'h00);
      end
      // Expansion with GPIO select, then with a segment select: upper pins carry controller signals
      bus_xfer(1'b1, port9_pkg::LCD_PORT_CTRL_ADDR, 32'h00000010);
      @(posedge mclk_in);
      check_pins({ctl_src, 4'h5}, 8'h0F);
      bus_xfer(1'b1, port9_pkg::LCD_PORT_CTRL_ADDR, 32'h0000001F);
      @(posedge mclk_in);
      check_pins({ctl_src, seg_src[3:0]}, 8'h00);
      ctl_src <= 4'h4;
      repeat (2) @(posedge mclk_in);
      check_pins({4'h4, seg_src[3:0]}, 8'h00);
      check_read(port9_pkg::LCD_PORT_CTRL_ADDR, 32'h0000001F);
      // Retained modes freeze the pins, standby floats them
      retain <= 1'b1;
      seg_src <= 8'hC3;
      ctl_src <= 4'hB;
      repeat (3) @(posedge mclk_in);
      check_pins({4'h4, 4'hA}, 8'h00);
      standby <= 1'b1;
      repeat (2) @(posedge mclk_in);
      check_pins(8'h00, 8'hFF);
      standby <= 1'b0;
      retain <= 1'b0;
      repeat (2) @(posedge mclk_in);
      check_pins({ctl_src, seg_src[3:0]}, 8'h00);
      // Second reset in mid-run clears the data register
      do_reset();
      check_pins(8'h00, 8'hFF);
      bus_xfer(1'b1, port9_pkg::PIN_DIRECTION_ADDR, 32'h000000FF);
      check_pins(8'h00, 8'h00);
      check_read(port9_pkg::OUTPUT_DATA_ADDR, 32'h00000000);
      finish_test();
   end
endmodule // testbench
